// *** logic/ramp_engine.sv ***
// Purpose: Divide-value engine: fractional word, keying, ramps, slip cells.
// Assumes: APB slave; serial words are written whole to the serial port.
// Notes:   All ramp timing advances only on the detector enable pulse.
//
// Added by the designer: the APB interface to the registers and the address map.
`timescale 1ns/1ps
// Function
// - Divide ratio is integer plus fraction over two to the 25.
// - Fraction is upper 12 bits shifted 13 plus lower 13 bits.
// - Detector rate: reference, doubled, divided by R, optionally halved.
// - Slip reduction adds one cell per imminent slip, up to seven.
// - Past the target, extra cells switch off one at a time.
// - Slip reduction enabled by bit 28 of reference register, with polarity bit 6 of function register set.
// - Frequency keying adds or subtracts shifted deviation by data pin.
// - Phase keying selects 0 or 180 degrees from the data pin.
// - Four waveforms: ramp burst, sawtooth burst, sawtooth, triangle.
// - Step interval is product of two 12-bit counts in detector cycles.
// - A 20-bit count sets steps per ramp segment.
// - Ramp burst adds deviation each interval, then holds final value.
// - Sawtooth burst restores initial value an interval after last step.
// - Continuous sawtooth repeats until ramp disabled.
// - Triangle subtracts for same count after rising, repeating.
// - Ramp starts on start bit 31 alone, in whichever mode the field holds.
// - Low three bits of a serial word select the target register.
// - Deviation bit 23 selects first or second deviation word.
module ramp_engine
	import ramp_pkg::*;
#(
	// Extra charge pump cells that slip reduction may switch on
	parameter int CELL_LIMIT = ramp_pkg::CELLS
)
(
	// Clock and reset
	input  wire logic                   CLOCK_IN,
	input  wire logic                   NRST_IN,
	// APB slave
	input  wire ramp_pkg::apb_req_t     APB_REQ_IN,
	output ramp_pkg::apb_rsp_t          APB_RSP_OUT,
	// Reference and modulation pins
	input  wire logic                   REF_TICK_IN,
	input  wire logic                   TX_DATA_IN,
	input  wire logic                   SLIP_IMMINENT_IN,
	input  wire logic                   PAST_TARGET_IN,
	// Divider and loop outputs
	output logic [ramp_pkg::INT_W-1:0]  INT_OUT,
	output logic [ramp_pkg::FRAC_W-1:0] FRAC_OUT,
	output logic                        PHASE_INVERT_OUT,
	output logic [ramp_pkg::CELLS-1:0]  CELL_EN_OUT,
	output logic                        PFD_TICK_OUT
);
	typedef struct packed {
		logic [31:0]      r0, r1, r2, r3, r4;
		logic [DEV_W-1:0] dev0, dev1;
		logic [SHIFT_W-1:0] sh0, sh1;
		logic [STEP_W-1:0] step0, step1;
		logic [31:0]      r7;
		ramp_state_t      st;
		logic [TIMER_W-1:0] t1, t2;
		logic [STEP_W-1:0] steps;
		logic [N_W-1:0]   ramp_n;
		logic [3:0]       cells;
		logic             wait_rep;
		logic             ready;
		logic [31:0]      rdata;
		logic [INT_W-1:0] int_o;
		logic [FRAC_W-1:0] frac_o;
		logic             phase;
		logic [CELLS-1:0] cell_en;
		logic             pfd;
	} eng_state_t;

	eng_state_t s;
	eng_state_t next_s;
	logic       pfd_tick;
	logic [N_W-1:0] base_n;
	logic [N_W-1:0] dev_n;
	logic [N_W-1:0] fsk_n;
	logic [N_W-1:0] out_n;
	logic [31:0] w;
	logic        wr;
	logic        rd;
	logic        running;
	logic        interval_end;
	ramp_mode_t  mode;

	// The thermometer output has room for CELLS cells and no more
	if (CELL_LIMIT < 1 || CELL_LIMIT > CELLS) begin : g_cell_limit
		$error("CELL_LIMIT must lie between 1 and CELLS");
	end
	// The divide word is integer, upper fraction and lower fraction
	if (FRAC_W != FRAC_HI_W + FRAC_LO_W) begin : g_frac_split
		$error("FRAC_W must equal FRAC_HI_W plus FRAC_LO_W");
	end

	pfd_divider i_pfd_divider (
		.clk      (CLOCK_IN),
		.nrst     (NRST_IN),
		.ref_tick (REF_TICK_IN),
		.doubler  (s.r2[REF_DBL_BIT]),
		.div2     (s.r2[REF_DIV2_BIT]),
		.r_div    (s.r2[REF_R_LSB +: 5]),
		.pfd_tick (pfd_tick)
	);

	function automatic logic [N_W-1:0] scaled(input logic [DEV_W-1:0] d,
			input logic [SHIFT_W-1:0] sh);
		logic [N_W-1:0] ext;
		ext = {{(N_W-DEV_W){d[DEV_W-1]}}, d};
		return ext << sh;
	endfunction : scaled

	always_comb begin
		next_s = s;
		w = APB_REQ_IN.pwdata;
		// Taken only while ready is low, so each transfer acts once
		wr = APB_REQ_IN.psel && APB_REQ_IN.penable && APB_REQ_IN.pwrite
			&& !s.ready;
		rd = APB_REQ_IN.psel && APB_REQ_IN.penable && !APB_REQ_IN.pwrite
			&& !s.ready;
		mode = ramp_mode_t'(s.r3[MODE_LSB +: 2]);
		// Mode field is read live; the start bit alone gates the run
		running = s.r0[RAMP_START];
		// Fraction over two to the 25 with the integer above it
		base_n = {s.r0[INT_LSB +: INT_W],
			s.r0[FRAC_HI_LSB +: FRAC_HI_W],
			s.r1[FRAC_LO_LSB +: FRAC_LO_W]};
		dev_n = scaled(s.dev0, s.sh0);
		// Keying uses word 1, so it can ride on a ramp built from word 0
		fsk_n = scaled(s.dev1, s.sh1);

		// Single-cycle APB answer; a second access phase cycle is refused
		next_s.ready = wr || rd;
		if (wr) begin
			if (APB_REQ_IN.paddr == OFF_SERIAL || APB_REQ_IN.paddr[7:5] == 3'h0)
			begin
				// Serial image: low three bits pick the target
				if (APB_REQ_IN.paddr != OFF_SERIAL)
					w[2:0] = APB_REQ_IN.paddr[4:2];
				case (w[2:0])
					3'h0: next_s.r0 = w;
					3'h1: next_s.r1 = w;
					3'h2: next_s.r2 = w;
					3'h3: next_s.r3 = w;
					3'h4: next_s.r4 = w;
					3'h5: begin
						if (w[WORD_SEL_BIT]) begin
							next_s.dev1 = w[DEV_LSB +: DEV_W];
							next_s.sh1 = w[SHIFT_LSB +: SHIFT_W];
						end else begin
							next_s.dev0 = w[DEV_LSB +: DEV_W];
							next_s.sh0 = w[SHIFT_LSB +: SHIFT_W];
						end
					end
					3'h6: begin
						if (w[WORD_SEL_BIT])
							next_s.step1 = w[STEP_LSB +: STEP_W];
						else
							next_s.step0 = w[STEP_LSB +: STEP_W];
					end
					ADDR_DELAY: next_s.r7 = w;
					default: ;
				endcase
			end
		end
		next_s.rdata = 32'h00000000;
		if (rd) begin
			if (APB_REQ_IN.paddr == OFF_INT_FRAC)
				next_s.rdata = s.r0;
			else if (APB_REQ_IN.paddr == OFF_LOW_FRAC)
				next_s.rdata = s.r1;
			else if (APB_REQ_IN.paddr == OFF_REF_DIV)
				next_s.rdata = s.r2;
			else if (APB_REQ_IN.paddr == OFF_FUNCTION)
				next_s.rdata = s.r3;
			else if (APB_REQ_IN.paddr == OFF_TEST)
				next_s.rdata = s.r4;
			else if (APB_REQ_IN.paddr == OFF_DEVIATION)
				next_s.rdata = {9'h000, s.sh0, s.dev0, 3'h5};
			else if (APB_REQ_IN.paddr == OFF_STEP)
				next_s.rdata = {9'h000, s.step0, 3'h6};
			else if (APB_REQ_IN.paddr == OFF_DELAY)
				next_s.rdata = s.r7;
			else if (APB_REQ_IN.paddr == OFF_STATUS)
				next_s.rdata = {s.steps, 4'h0, s.cells,
					2'(s.st), 1'b0, running};
			else if (APB_REQ_IN.paddr == OFF_DIVIDE)
				next_s.rdata = {16'h0000, s.int_o};
			else if (APB_REQ_IN.paddr == OFF_FRAC_OUT)
				next_s.rdata = {7'h00, s.frac_o};
			else if (APB_REQ_IN.paddr == OFF_CSR_CTRL)
				next_s.rdata = {25'h0000000, s.cell_en};
		end

		// Ramp timer: first count nested inside second count
		interval_end = pfd_tick && s.t1 + 12'h001 >= s.r2[MOD_LSB +: TIMER_W]
			&& s.t2 + 12'h001 >= s.r4[CLKDIV_LSB +: TIMER_W];
		if (!running) begin
			next_s.st = ST_IDLE;
			next_s.t1 = '0;
			next_s.t2 = '0;
			next_s.steps = '0;
			next_s.ramp_n = '0;
			next_s.wait_rep = 1'b0;
		end else if (s.st == ST_IDLE) begin
			next_s.st = ST_UP;
			next_s.t1 = '0;
			next_s.t2 = '0;
			next_s.steps = '0;
			next_s.ramp_n = '0;
		// Hold freezes the timer; a new run needs the start bit cleared
		end else if (pfd_tick && s.st != ST_HOLD) begin
			if (interval_end) begin
				next_s.t1 = '0;
				next_s.t2 = '0;
			end else if (s.t1 + 12'h001 >= s.r2[MOD_LSB +: TIMER_W]) begin
				next_s.t1 = '0;
				next_s.t2 = s.t2 + 12'h001;
			end else begin
				next_s.t1 = s.t1 + 12'h001;
			end
			if (interval_end) begin
				if (s.wait_rep) begin
					// Interval after the last step: back to the start
					next_s.wait_rep = 1'b0;
					next_s.ramp_n = '0;
					next_s.steps = '0;
					next_s.st = (mode == MODE_SAW_CONT) ? ST_UP
						: ST_HOLD;
				end else if (s.st == ST_UP) begin
					next_s.ramp_n = s.ramp_n + dev_n;
					next_s.steps = s.steps + 20'h00001;
					if (s.steps + 20'h00001 >= s.step0) begin
						next_s.steps = '0;
						case (mode)
							MODE_TRIANGLE: next_s.st = ST_DOWN;
							MODE_RAMP_ONCE: next_s.st = ST_HOLD;
							default: next_s.wait_rep = 1'b1;
						endcase
					end
				end else begin
					next_s.ramp_n = s.ramp_n - dev_n;
					next_s.steps = s.steps + 20'h00001;
					if (s.steps + 20'h00001 >= s.step0) begin
						next_s.steps = '0;
						next_s.st = ST_UP;
					end
				end
			end
		end

		// Keying on the data pin around the programmed centre
		out_n = base_n + s.ramp_n;
		if (s.r3[FSK_EN_BIT])
			out_n = TX_DATA_IN ? out_n + fsk_n : out_n - fsk_n;
		next_s.int_o = out_n[N_W-1 -: INT_W];
		next_s.frac_o = out_n[FRAC_W-1:0];
		next_s.phase = s.r3[PSK_EN_BIT] && TX_DATA_IN;

		// Extra charge pump cells, counted up and down one per cycle
		// Slip cells only work with positive detector polarity.
		// Past target wins over slip: more current would only overshoot.
		if (!s.r2[CSR_EN_BIT] || !s.r3[PD_POL_BIT]) begin
			next_s.cells = 4'h0;
		end else if (PAST_TARGET_IN) begin
			if (s.cells != 4'h0)
				next_s.cells = s.cells - 4'h1;
		end else if (SLIP_IMMINENT_IN && s.cells < 4'(CELL_LIMIT)) begin
			next_s.cells = s.cells + 4'h1;
		end
		// Thermometer code: cell n is on only while cells below it are on
		next_s.cell_en = CELLS'((8'h01 << next_s.cells) - 8'h01);
		// Detector pulse shown one cycle late, in step with other outputs
		next_s.pfd = pfd_tick;
	end

	// Synchronous reset clears every register image and every output
	always_ff @(posedge CLOCK_IN) begin
		if (!NRST_IN) begin
			s <= '0;
			s.st <= ST_IDLE;
		end else begin
			s <= next_s;
		end
	end

	// Every output but pslverr, which is tied low, is a flip-flop of the state image
	always_comb begin
		APB_RSP_OUT.pready = s.ready;
		APB_RSP_OUT.pslverr = 1'b0;
		APB_RSP_OUT.prdata = s.rdata;
		INT_OUT = s.int_o;
		FRAC_OUT = s.frac_o;
		PHASE_INVERT_OUT = s.phase;
		CELL_EN_OUT = s.cell_en;
		PFD_TICK_OUT = s.pfd;
	end
endmodule : ramp_engine

// *** logic/ramp_pkg.sv ***
// Purpose: Shared constants and carriers for the frequency ramp engine.
// Assumes: 32-bit APB registers, one aligned word each.
// Notes:   Serial-word images are stored whole, except deviation and step words; fields are picked here.
package ramp_pkg;
	// Register byte offsets
	localparam logic [7:0] OFF_INT_FRAC   = 8'h00;
	localparam logic [7:0] OFF_LOW_FRAC   = 8'h04;
	localparam logic [7:0] OFF_REF_DIV    = 8'h08;
	localparam logic [7:0] OFF_FUNCTION   = 8'h0C;
	localparam logic [7:0] OFF_TEST       = 8'h10;
	localparam logic [7:0] OFF_DEVIATION  = 8'h14;
	localparam logic [7:0] OFF_STEP       = 8'h18;
	localparam logic [7:0] OFF_DELAY      = 8'h1C;
	localparam logic [7:0] OFF_STATUS     = 8'h20;
	localparam logic [7:0] OFF_DIVIDE     = 8'h24;
	localparam logic [7:0] OFF_FRAC_OUT   = 8'h28;
	localparam logic [7:0] OFF_CSR_CTRL   = 8'h2C;
	localparam logic [7:0] OFF_SERIAL     = 8'h30;
	// Field positions
	localparam int SEL_LSB       = 0;
	localparam int RAMP_START    = 31;
	localparam int INT_LSB       = 15;
	localparam int FRAC_HI_LSB   = 3;
	localparam int FRAC_LO_LSB   = 15;
	localparam int CSR_EN_BIT    = 28;
	localparam int REF_DBL_BIT   = 20;
	localparam int REF_DIV2_BIT  = 21;
	localparam int REF_R_LSB     = 15;
	localparam int MOD_LSB       = 3;
	localparam int MODE_LSB      = 10;
	localparam int PSK_EN_BIT    = 9;
	localparam int FSK_EN_BIT    = 8;
	localparam int PD_POL_BIT    = 6;
	localparam int CLKDIV_LSB    = 7;
	localparam int WORD_SEL_BIT  = 23;
	localparam int SHIFT_LSB     = 19;
	localparam int DEV_LSB       = 3;
	localparam int STEP_LSB      = 3;
	// Widths
	localparam int INT_W    = 16;
	localparam int FRAC_W   = 25;
	localparam int FRAC_HI_W = 12;
	localparam int FRAC_LO_W = 13;
	localparam int DEV_W    = 16;
	localparam int SHIFT_W  = 4;
	localparam int TIMER_W  = 12;
	localparam int STEP_W   = 20;
	localparam int CELLS    = 7;
	localparam int N_W      = INT_W + FRAC_W;
	localparam logic [2:0] ADDR_DELAY = 3'h7;
	localparam logic [31:0] RESET_WORD = 32'h00000000;

	typedef enum logic [1:0] {
		MODE_SAW_CONT = 2'h0,
		MODE_TRIANGLE = 2'h1,
		MODE_SAW_ONCE = 2'h2,
		MODE_RAMP_ONCE = 2'h3
	} ramp_mode_t;

	typedef enum {ST_IDLE, ST_UP, ST_DOWN, ST_HOLD} ramp_state_t;

	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [7:0]  paddr;
		logic [31:0] pwdata;
	} apb_req_t;

	typedef struct packed {
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
	} apb_rsp_t;
endpackage : ramp_pkg

// *** logic/pfd_divider.sv ***
// Purpose: Derives the detector-rate enable pulse from the reference tick.
// Assumes: Reference arrives as a one-cycle pulse at a steady rate.
// Notes:   Ratio is (R x (1+T)) / (1+D) reference ticks per pulse.
`timescale 1ns/1ps
module pfd_divider (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       nrst,
	// Reference tick and settings
	input  wire logic       ref_tick,
	input  wire logic       doubler,
	input  wire logic       div2,
	input  wire logic [4:0] r_div,
	// Detector enable
	output logic            pfd_tick
);
	typedef struct packed {
		logic [6:0] cnt;
		logic [7:0] since;
		logic [7:0] half;
		logic       tick;
	} div_state_t;

	div_state_t s;
	div_state_t next_s;
	logic [6:0] span;
	logic       mid;

	always_comb begin
		// R of zero means 32; the halving stage doubles the count
		span = {2'h0, (r_div == 5'h00) ? 5'h1F : r_div - 5'h01} + 7'h01;
		if (div2)
			span = {span[5:0], 1'b0};
		// Doubler: a second event half a measured reference period later.
		// A reference slower than 256 clocks saturates the measurement.
		mid = doubler && s.half != 8'h00 && s.since + 8'h01 == s.half;
		next_s = s;
		next_s.tick = 1'b0;
		if (ref_tick) begin
			next_s.since = 8'h00;
			next_s.half = {1'b0, s.since[7:1]} + {7'h00, s.since[0]};
		end else if (s.since != 8'hFF) begin
			next_s.since = s.since + 8'h01;
		end
		if (ref_tick || mid) begin
			if (s.cnt + 7'h01 >= span) begin
				next_s.cnt = 7'h00;
				next_s.tick = 1'b1;
			end else begin
				next_s.cnt = s.cnt + 7'h01;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst)
			s <= '0;
		else
			s <= next_s;
	end

	assign pfd_tick = s.tick;
endmodule : pfd_divider

// *** verif/ramp_engine_chk_sva.sv ***
// Purpose: Port-level checks for the ramp engine.
// Assumes: Outputs move one cycle after their causes.
// Notes:   Bound from the bench top file.
`timescale 1ns/1ps
module ramp_engine_chk
	import ramp_pkg::*;
(
	// Clock, reset and inputs
	input wire logic                        CLOCK_IN,
	input wire logic                        NRST_IN,
	input wire ramp_pkg::apb_req_t          APB_REQ_IN,
	input wire logic                        REF_TICK_IN,
	input wire logic                        TX_DATA_IN,
	input wire logic                        SLIP_IMMINENT_IN,
	input wire logic                        PAST_TARGET_IN,
	// Outputs
	input wire ramp_pkg::apb_rsp_t          APB_RSP_OUT,
	input wire logic [ramp_pkg::INT_W-1:0]  INT_OUT,
	input wire logic [ramp_pkg::FRAC_W-1:0] FRAC_OUT,
	input wire logic                        PHASE_INVERT_OUT,
	input wire logic [ramp_pkg::CELLS-1:0]  CELL_EN_OUT,
	input wire logic                        PFD_TICK_OUT
);
	default clocking cb @(posedge CLOCK_IN); endclocking
	default disable iff (!NRST_IN);
	cell_therm_a: assert property (
		(CELL_EN_OUT & (CELL_EN_OUT + 7'h01)) == 7'h00)
		else $error("cells not a thermometer");
	cell_full_a: assert property (
		CELL_EN_OUT == 7'h7F && SLIP_IMMINENT_IN && !PAST_TARGET_IN
		|=> CELL_EN_OUT == 7'h7F) else $error("cells beyond seven");
	cell_rise_a: assert property (
		$countones(CELL_EN_OUT) > $countones($past(CELL_EN_OUT))
		|-> $past(SLIP_IMMINENT_IN)
		&& CELL_EN_OUT == (($past(CELL_EN_OUT) << 1) | 7'h01))
		else $error("cell added without slip");
	cell_drop_a: assert property (
		PAST_TARGET_IN && CELL_EN_OUT != 7'h00
		|=> CELL_EN_OUT == ($past(CELL_EN_OUT) >> 1))
		else $error("cells not removed one by one");
	cell_hold_a: assert property (
		!SLIP_IMMINENT_IN && !PAST_TARGET_IN
		&& !(APB_REQ_IN.psel && APB_REQ_IN.penable)
		|=> $stable(CELL_EN_OUT))
		else $error("cells moved without cause");
	phase_follow_a: assert property (
		PHASE_INVERT_OUT |-> $past(TX_DATA_IN))
		else $error("phase inverted with data low");
	pfd_pulse_a: assert property (
		PFD_TICK_OUT |=> !PFD_TICK_OUT) else $error("detector pulse too long");
	div_cause_a: assert property (
		!$stable({INT_OUT, FRAC_OUT}) |-> PFD_TICK_OUT
		|| $past(PFD_TICK_OUT) || $past(PFD_TICK_OUT, 2)
		|| $past(APB_REQ_IN.penable) || $past(APB_REQ_IN.penable, 2)
		|| $past(TX_DATA_IN) != $past(TX_DATA_IN, 3))
		else $error("divide value moved off a boundary");
endmodule : ramp_engine_chk

// *** verif/ramp_host.sv ***
// Purpose: Host model that programs the engine over APB.
// Assumes: Tasks are entered just after a rising edge.
// Notes:   Serial words go whole to the serial port.
`timescale 1ns/1ps
module ramp_host
	import ramp_pkg::*;
(
	// Bus side
	input  wire logic               clk,
	input  wire ramp_pkg::apb_rsp_t rsp,
	output ramp_pkg::apb_req_t      req
);
	initial req = '0;
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q);
		req <= {1'b1, 1'b0, w, a, d};
		@(posedge clk);
		req.penable <= 1'b1;
		do @(posedge clk); while (rsp.pready !== 1'b1);
		q = rsp.prdata;
		// Released fields flip so stale values never look valid
		req <= {2'b00, w, ~a, ~d};
		@(posedge clk);
	endtask : xfer
	task automatic sw(input logic [31:0] d);
		logic [31:0] q;
		xfer(1'b1, OFF_SERIAL, d, q);
	endtask : sw
	task automatic init(input logic [31:0] s0, s1, v0, v1, ts, fn, rf, lo, hi);
		sw(32'h00000007);
		sw(s0);
		sw(s1);
		sw(v0);
		sw(v1);
		sw(ts);
		sw(fn);
		sw(rf);
		sw(lo);
		sw(hi);
	endtask : init
endmodule : ramp_host

// *** verif/ramp_engine_tb.sv ***
// Purpose: Self-checking bench for the ramp engine.
// Assumes: Reference tick every four clocks, detector at ref/2.
// Notes:   Timer counts are kept small so ramps finish quickly.
`timescale 1ns/1ps
module ramp_engine_tb;
	import ramp_pkg::*;
	logic             clk, nrst, ref_tick, tx, slip, past, ph, pfd;
	apb_req_t         req;
	apb_rsp_t         rsp;
	logic [INT_W-1:0] int_o;
	logic [FRAC_W-1:0] frac_o;
	logic [CELLS-1:0] cells;
	logic [40:0]      c, d0, d1, n, prev, mx, dh;
	logic [31:0]      q;
	logic [15:0]      iv, dv0, dv1;
	logic [11:0]      fh;
	logic [12:0]      fl;
	logic [3:0]       sh0, sh1;
	int bad_count, check_count, rc, ret, t1, t2, g, k, j;
	int rt[4] = '{2, 2, 1, 3};
	int tt[4] = '{0, 1, 0, 1};
	int dt[4] = '{0, 0, 1, 0};
	initial clk = 1'b0;
	always #2.5 clk = ~clk;
	always @(posedge clk) begin
		rc <= (rc + 1) % 4;
		ref_tick <= (rc == 2);
	end
	ramp_engine i_ramp_engine(.CLOCK_IN(clk), .NRST_IN(nrst),
		.APB_REQ_IN(req), .APB_RSP_OUT(rsp), .REF_TICK_IN(ref_tick),
		.TX_DATA_IN(tx), .SLIP_IMMINENT_IN(slip), .PAST_TARGET_IN(past),
		.INT_OUT(int_o), .FRAC_OUT(frac_o), .PHASE_INVERT_OUT(ph),
		.CELL_EN_OUT(cells), .PFD_TICK_OUT(pfd));
	ramp_host i_ramp_host(.clk(clk), .rsp(rsp), .req(req));
	function automatic logic [31:0] w_int(logic s, logic [15:0] i,
		logic [11:0] f);
		return {s, i, f, 3'h0};
	endfunction : w_int
	function automatic logic [31:0] w_ref(logic cs, logic t, logic d,
		logic [4:0] r);
		return {3'h0, cs, 6'h00, t, d, r, 12'h002, 3'h2};
	endfunction : w_ref
	function automatic logic [31:0] w_fn(logic [1:0] m, logic p, logic f);
		return {20'h00000, m, p, f, 2'b01, 3'h0, 3'h3};
	endfunction : w_fn
	task automatic chk(string nm, logic [40:0] seen, logic [40:0] exp);
		check_count++;
		if (seen !== exp) begin
			bad_count++;
			$display("[FAIL] %s exp %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic gap(output int w);
		w = 0;
		do @(posedge clk); while (pfd !== 1'b1);
		do begin
			@(posedge clk);
			w++;
		end while (pfd !== 1'b1);
	endtask : gap
	task automatic summarize();
		if (bad_count == 0 && check_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : summarize
	initial begin
		#200000;
		bad_count++;
		summarize();
	end
	initial begin
		{nrst, tx, slip, past, bad_count, check_count} = '0;
		void'($urandom(59200));
		dv0 = 16'($urandom % 200 + 1);
		sh0 = 4'($urandom % 3);
		dv1 = 16'($urandom % 200 + 1);
		sh1 = 4'($urandom % 3);
		d0 = 41'(dv0) << sh0;
		d1 = 41'(dv1) << sh1;
		repeat (6) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		// Detector at ref/2 and small steps
		i_ramp_host.init({8'h00, 1'b0, 20'h00003, 3'h6},
			{8'h00, 1'b1, 20'h00005, 3'h6}, {8'h00, 1'b0, sh0, dv0, 3'h5},
			{8'h00, 1'b1, sh1, dv1, 3'h5}, {13'h0000, 12'h002, 7'h04},
			w_fn(2'h3, 1'b0, 1'b0), w_ref(1'b0, 1'b0, 1'b0, 5'h02),
			32'h00000001, w_int(1'b0, 16'h0100, 12'h000));
		for (k = 0; k < 4; k++) begin
			iv = 16'h0100 + 16'($urandom % 256);
			fh = (k == 0) ? 12'hFFF : 12'($urandom);
			fl = (k == 0) ? 13'h1FFF : 13'($urandom);
			i_ramp_host.sw({4'h0, fl, 12'h000, 3'h1});
			i_ramp_host.sw(w_int(1'b0, iv, fh));
			c = {iv, fh, fl};
			repeat (3) @(posedge clk);
			chk("divide", {int_o, frac_o}, c);
		end
		i_ramp_host.xfer(1'b0, 8'h3C, 32'h0, q);
		chk("unmapped", 41'(q), 41'h0);
		i_ramp_host.xfer(1'b0, OFF_FRAC_OUT, 32'h0, q);
		chk("frac read", 41'(q), 41'({fh, fl}));
		for (k = 0; k < 4; k++) begin
			i_ramp_host.sw(w_ref(1'b0, 1'(tt[k]), 1'(dt[k]), 5'(rt[k])));
			gap(g);
			gap(g);
			chk("pfd gap", 41'(g), 41'(4 * rt[k] * (1 + tt[k]) / (1 + dt[k])));
		end
		i_ramp_host.sw(w_ref(1'b0, 1'b0, 1'b0, 5'h02));
		i_ramp_host.sw(w_fn(2'h3, 1'b1, 1'b1));
		tx <= 1'b1;
		repeat (4) @(posedge clk);
		dh = {int_o, frac_o};
		chk("phase hi", 41'(ph), 41'h1);
		tx <= 1'b0;
		repeat (4) @(posedge clk);
		chk("phase lo", 41'(ph), 41'h0);
		chk("fsk high", dh, c + d1);
		chk("fsk low", {int_o, frac_o}, c - d1);
		i_ramp_host.sw(w_fn(2'h3, 1'b0, 1'b0));
		slip <= 1'b1;
		repeat (3) @(posedge clk);
		slip <= 1'b0;
		repeat (2) @(posedge clk);
		chk("slip off", 41'(cells), 41'h0);
		i_ramp_host.sw(w_ref(1'b1, 1'b0, 1'b0, 5'h02));
		j = $urandom % 6 + 1;
		for (k = 0; k < 4; k++) begin
			slip <= (k < 2);
			past <= (k >= 2);
			repeat (k == 0 ? j : k == 1 ? 9 : k == 2 ? 1 : 8) @(posedge clk);
			{slip, past} <= 2'b00;
			repeat (2) @(posedge clk);
			chk("cells", 41'(cells), 41'(k == 0 ? (1 << j) - 1 : k == 1 ? 127
				: k == 2 ? 63 : 0));
		end
		i_ramp_host.sw(w_ref(1'b0, 1'b0, 1'b0, 5'h02));
		for (k = 0; k < 4; k++) begin
			i_ramp_host.sw(w_fn(2'(k), 1'b0, 1'b0));
			repeat (40) @(posedge clk);
			chk("no start", {int_o, frac_o}, c);
			i_ramp_host.sw(w_int(1'b1, iv, fh));
			{mx, prev, ret, t1, t2} = {c, c, 96'h0};
			for (g = 1; g < 1200; g++) begin
				@(posedge clk);
				n = {int_o, frac_o};
				if (n != prev && t1 != 0 && t2 == 0)
					t2 = g;
				if (n != prev && t1 == 0)
					t1 = g;
				if (n == c && prev != c)
					ret++;
				if (n > mx)
					mx = n;
				prev = n;
			end
			chk("interval", 41'(t2 - t1), 41'd32);
			chk("peak", mx, c + 3 * d0);
			if (k == 3)
				chk("hold", n, c + 3 * d0);
			if (k == 2)
				chk("once", 41'(ret), 41'h1);
			if (k < 2)
				chk("repeat", 41'(ret > 2), 41'h1);
			i_ramp_host.sw(w_int(1'b0, iv, fh));
			repeat (4) @(posedge clk);
			chk("stop", {int_o, frac_o}, c);
		end
		summarize();
	end
endmodule : ramp_engine_tb
bind ramp_engine ramp_engine_chk i_ramp_engine_chk(.CLOCK_IN(CLOCK_IN),
	.NRST_IN(NRST_IN), .APB_REQ_IN(APB_REQ_IN), .APB_RSP_OUT(APB_RSP_OUT),
	.REF_TICK_IN(REF_TICK_IN), .TX_DATA_IN(TX_DATA_IN),
	.SLIP_IMMINENT_IN(SLIP_IMMINENT_IN), .PAST_TARGET_IN(PAST_TARGET_IN),
	.INT_OUT(INT_OUT), .FRAC_OUT(FRAC_OUT),
	.PHASE_INVERT_OUT(PHASE_INVERT_OUT), .CELL_EN_OUT(CELL_EN_OUT),
	.PFD_TICK_OUT(PFD_TICK_OUT));
